// ### bench/jtd_chk_asserts.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Link timing and shift-state checks
// ----------------------------------------
module jtd_chk (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic tck,
    input wire logic tms,
    input wire logic tdi,
    input wire logic tdo,
    input wire logic tdo_oe,
    input wire logic rst_o
);
    a_tck_half_period: assert property (@(posedge sys_clk) disable iff (sys_rst)
        $rose(tck) |-> tck [*4] ##1 !tck) else $error("tck half period wrong");
    a_tms_on_fall: assert property (@(posedge sys_clk) disable iff (sys_rst)
        $changed(tms) |-> !tck) else $error("tms moved while tck high");
    a_tdi_on_fall: assert property (@(posedge sys_clk) disable iff (sys_rst)
        $changed(tdi) |-> !tck) else $error("tdi moved while tck high");
    a_rst_open_drain: assert property (@(posedge sys_clk) disable iff (sys_rst)
        !rst_o) else $error("reset line driven high");
    a_oe_enter_shift: assert property (@(posedge tck) disable iff (sys_rst)
        $rose(tdo_oe) |-> !$past(tms) && !$past(tms, 2)) else $error("tdo on outside shift");
    a_oe_leave_shift: assert property (@(posedge tck) disable iff (sys_rst)
        $fell(tdo_oe) |-> $past(tms)) else $error("tdo off without tms high");
    a_ir_capture_out: assert property (@(posedge tck) disable iff (sys_rst)
        $rose(tdo_oe) && $past(tms, 4) |-> tdo ##1 !tdo [*3]) else $error("ir capture not 0x1");
    a_five_tms_reset: assert property (@(posedge tck) disable iff (sys_rst)
        tms [*5] |=> !tdo_oe) else $error("tdo on after tms reset");
endmodule
`default_nettype wire

// ### bench/tb_jtag_tap_debug_access.sv
`timescale 1ns/1ps
`default_nettype none
`include "jtd_cfg.svh"
// ----------------------------------------
// Probe to device scan bench
// ----------------------------------------
module tb_jtag_tap_debug_access;
    logic        sys_clk, sys_rst, fuse, sdis, ocd, pcv, bki, vld, srq;
    logic        gpio, pue, bsd, pm, pstb, halt, rdy, rv, seen;
    logic [7:0]  bsi, isi, bso, iso;
    logic [14:0] prd, pcmd;
    logic [15:0] pc;
    logic [1:0]  kind;
    logic [6:0]  nb;
    logic [67:0] dat, rsp, rd, d;
    logic [31:0] seed;
    int          err_total, tests_run, hits, n, stbs;
    jtd_if jif();
    jtd_tap jtd_tap_inst (.sys_clk(sys_clk), .sys_rst(sys_rst), .scan_port_enable_fuse(fuse),
        .scan_port_soft_disable(sdis), .ocd_enable(ocd), .pins_gpio_mode(gpio), .pullup_en(pue),
        .bsr_in(bsi), .bsr_out(bso), .bsr_drive(bsd), .prog_mode(pm), .prog_cmd(pcmd),
        .prog_cmd_stb(pstb), .prog_rdata(prd), .iscan_in(isi), .iscan_out(iso), .pc(pc),
        .pc_valid(pcv), .flow_change(1'b0), .brk_instr(bki), .daddr(16'h0000),
        .dacc_valid(1'b0), .halt(halt), .jif(jif));
    jtd_probe jtd_probe_inst (.sys_clk(sys_clk), .sys_rst(sys_rst), .req_valid(vld),
        .req_ready(rdy), .req_kind(kind), .req_nbits(nb), .req_data(dat), .resp_valid(rv),
        .resp_data(rd), .sys_reset_req(srq), .sys_reset_seen(seen), .jif(jif));
    jtd_chk jtd_chk_inst (.sys_clk(sys_clk), .sys_rst(sys_rst), .tck(jif.tck), .tms(jif.tms),
        .tdi(jif.tdi), .tdo(jif.tdo), .tdo_oe(jif.tdo_oe), .rst_o(jif.rst_o));
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // Response holds only the shifted bits; upper bits read zero
    function automatic logic [67:0] msk(logic [67:0] v, int w);
        return v & ({68{1'b1}} >> (68 - w));
    endfunction
    task automatic chk(input logic [67:0] got, input logic [67:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic scan(input logic [1:0] k, input int w, input logic [67:0] v);
        int i;
        kind = k;
        nb = 7'(w);
        dat = v;
        vld = 1'b1;
        i = 0;
        #1;
        while (rdy !== 1'b1 && i < 4000) begin
            @(negedge sys_clk);
            #1;
            i++;
        end
        if (i >= 4000) begin
            err_total++;
            complete_run();
        end
        @(negedge sys_clk);
        vld = 1'b0;
        i = 0;
        while (k != 2'h2 && rv !== 1'b1 && i < 4000) begin
            @(posedge sys_clk);
            #1;
            i++;
        end
        if (i >= 4000) begin
            err_total++;
            complete_run();
        end
        rsp = rd;
        @(negedge sys_clk);
    endtask
    task automatic pls(input logic [15:0] a, input logic b);
        pc = a;
        pcv = ~b;
        bki = b;
        @(negedge sys_clk);
        pcv = 1'b0;
        bki = 1'b0;
        repeat (6) @(negedge sys_clk);
    endtask
    task automatic complete_run();
        $display("errors=%0d checks=%0d", err_total, tests_run);
        if (err_total == 0 && tests_run > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    always @(posedge sys_clk) if (halt === 1'b1) hits++;
    always @(posedge sys_clk) if (pstb === 1'b1) stbs++;
    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end
    initial begin
        #1000000;
        err_total++;
        complete_run();
    end
    initial begin
        {sys_rst, fuse, sdis, ocd, pcv, bki, vld, srq} = 8'h c0;
        {bsi, isi, prd, pc, kind, nb, dat} = '0;
        {err_total, tests_run, hits, stbs} = '0;
        seed = 32'h00010af6;
        repeat (2) @(posedge sys_clk);
        @(negedge sys_clk);
        sys_rst = 1'b0;
        scan(2'h1, 4, `JTD_I_IDCODE);
        chk(rsp, 68'h1);
        scan(2'h0, 32, 68'(rnd()));
        chk(rsp, 68'(`JTD_IDCODE));
        scan(2'h1, 4, `JTD_I_BYPASS);
        repeat (6) begin
            n = (rnd() % 68) + 1;
            d = 68'({rnd(), rnd(), rnd()});
            scan(2'h0, n, d);
            chk(rsp, msk(d << 1, n));
        end
        bsi = 8'(rnd());
        scan(2'h1, 4, `JTD_I_SAMPLE);
        scan(2'h0, 8, 68'h0);
        chk(rsp, 68'(bsi));
        d = 68'(rnd() & 32'h000000ff);
        scan(2'h1, 4, `JTD_I_EXTEST);
        scan(2'h0, 8, d);
        repeat (16) @(negedge sys_clk);
        chk({bsd, bso}, {1'b1, d[7:0]});
        prd = 15'(rnd());
        d = 68'(rnd() & 32'h00007fff);
        scan(2'h1, 4, `JTD_I_PROG_EN);
        scan(2'h0, 16, 68'(`JTD_PROG_KEY));
        scan(2'h1, 4, `JTD_I_PROG_CMD);
        scan(2'h0, 15, d);
        repeat (16) @(negedge sys_clk);
        chk({pm, pcmd}, {1'b1, d[14:0]});
        chk(68'(stbs), 68'h1);
        chk(rsp, 68'(prd));
        isi = 8'(rnd());
        scan(2'h1, 4, `JTD_I_INTSCAN);
        scan(2'h0, 8, d);
        chk(rsp, msk(d << 1, 8));
        ocd = 1'b1;
        scan(2'h1, 4, `JTD_I_INTSCAN);
        scan(2'h0, 8, d);
        repeat (16) @(negedge sys_clk);
        chk({rsp[7:0], iso}, {isi, d[7:0]});
        scan(2'h1, 4, `JTD_I_BRKSCAN);
        scan(2'h0, 68, {4'h1, 32'h0, 16'h01ff, 16'h0100});
        repeat (16) @(negedge sys_clk);
        hits = 0;
        pls(16'h0150, 1'b0);
        pls(16'h0200, 1'b0);
        chk(68'(hits), 68'h1);
        pls(16'h0000, 1'b1);
        chk(68'(hits), 68'h2);
        srq = 1'b1;
        repeat (8) @(negedge sys_clk);
        chk(68'(seen), 68'h1);
        srq = 1'b0;
        sdis = 1'b1;
        repeat (8) @(negedge sys_clk);
        chk({seen, gpio, pue}, 3'h2);
        scan(2'h1, 4, `JTD_I_IDCODE);
        chk(rsp, 68'hf);
        sdis = 1'b0;
        repeat (8) @(negedge sys_clk);
        chk({gpio, pue}, 2'h1);
        scan(2'h2, 1, 68'h0);
        d = 68'(rnd());
        scan(2'h1, 4, `JTD_I_BYPASS);
        scan(2'h0, 8, d);
        chk(rsp, msk(d << 1, 8));
        scan(2'h2, 1, 68'h0);
        scan(2'h0, 32, 68'h0);
        chk(rsp, 68'(`JTD_IDCODE));
        complete_run();
    end
endmodule
`default_nettype wire

// ### core/jtd_cfg.svh
`ifndef JTD_CFG_SVH
`define JTD_CFG_SVH

// ----------------------------------------------------------------------
// Instruction register
// ----------------------------------------------------------------------
`define JTD_IR_W        4
`define JTD_IR_CAPTURE  4'h1
`define JTD_I_EXTEST    4'h0
`define JTD_I_IDCODE    4'h1
`define JTD_I_SAMPLE    4'h2
`define JTD_I_PROG_EN   4'h4
`define JTD_I_PROG_CMD  4'h5
`define JTD_I_INTSCAN   4'h8
`define JTD_I_BRKSCAN   4'h9
`define JTD_I_BYPASS    4'hf

// ----------------------------------------------------------------------
// Data register lengths and values
// ----------------------------------------------------------------------
`define JTD_SR_W        68
`define JTD_LEN_W       7
`define JTD_ID_W        7'h20
`define JTD_IDCODE      32'h1234_5001
`define JTD_BSR_W       8
`define JTD_PKEY_W      16
`define JTD_PROG_KEY    16'h5a3c
`define JTD_PCMD_W      15
`define JTD_ISC_W       8
`define JTD_ADDR_W      16
`define JTD_BRK_W       68
`define JTD_BRK_PC_LO   0
`define JTD_BRK_PC_HI   16
`define JTD_BRK_DA_LO   32
`define JTD_BRK_DA_HI   48
`define JTD_BRK_PC_EN   64
`define JTD_BRK_DA_EN   65
`define JTD_BRK_FLOW    66
`define JTD_BRK_STEP    67

// ----------------------------------------------------------------------
// Probe timing
// ----------------------------------------------------------------------
`define JTD_RESET_TMS_N 7'h05
`define JTD_TCK_HALF    3'h4
`define JTD_KIND_DR     2'h0
`define JTD_KIND_IR     2'h1
`define JTD_KIND_RESET  2'h2

`endif

// ### core/jtd_if.sv
`timescale 1ns/1ps
`default_nettype none

interface jtd_if;
    logic tck;
    logic tms;
    logic tdi;
    logic tdo;
    logic tdo_oe;
    logic tdo_line;
    logic rst_o;
    logic rst_oe;
    logic rst_line;

    // Pulled-up lines: undriven reads high
    assign tdo_line = tdo_oe ? tdo : 1'b1;
    assign rst_line = rst_oe ? rst_o : 1'b1;

    modport dev (input tck, input tms, input tdi, output tdo, output tdo_oe);
    modport probe (output tck, output tms, output tdi, input tdo_line,
                   output rst_o, output rst_oe, input rst_line);
endinterface

`default_nettype wire

// ### core/jtd_pkg.sv
`include "jtd_cfg.svh"

package jtd_pkg;

    typedef enum logic [15:0] {
        T_TLR = 16'h0001, T_RTI = 16'h0002, T_SDS = 16'h0004, T_CDR = 16'h0008,
        T_SDR = 16'h0010, T_E1D = 16'h0020, T_PDR = 16'h0040, T_E2D = 16'h0080,
        T_UDR = 16'h0100, T_SIS = 16'h0200, T_CIR = 16'h0400, T_SIR = 16'h0800,
        T_E1I = 16'h1000, T_PIR = 16'h2000, T_E2I = 16'h4000, T_UIR = 16'h8000
    } jtd_tap_t;

    typedef enum logic [4:0] {
        P_RST = 5'h01, P_IDL = 5'h02, P_SEL = 5'h04, P_SHF = 5'h08, P_EXT = 5'h10
    } jtd_pst_t;

    typedef struct packed {
        jtd_tap_t                st;
        logic [`JTD_IR_W-1:0]    ir;
        logic [`JTD_SR_W-1:0]    sr;
        logic [`JTD_BSR_W-1:0]   bsr;
        logic [`JTD_PCMD_W-1:0]  pcmd;
        logic                    pmode;
        logic [`JTD_ISC_W-1:0]   isc;
        logic [`JTD_BRK_W-1:0]   brk;
        logic                    tgl;
    } jtd_dtck_t;

    typedef struct packed {
        logic                    tgl_last;
        logic [`JTD_BSR_W-1:0]   bsr;
        logic                    bsr_drive;
        logic [`JTD_PCMD_W-1:0]  pcmd;
        logic                    pstb;
        logic                    pmode;
        logic [`JTD_ISC_W-1:0]   isc;
        logic [`JTD_BRK_W-1:0]   brk;
        logic                    halt;
    } jtd_dsys_t;

    typedef struct packed {
        jtd_pst_t                st;
        logic [2:0]              div;
        logic                    tck;
        logic                    tms;
        logic                    tdi;
        logic [`JTD_LEN_W-1:0]   cnt;
        logic [`JTD_LEN_W-1:0]   idx;
        logic [`JTD_LEN_W-1:0]   n;
        logic [3:0]              seq;
        logic                    samp;
        logic [`JTD_SR_W-1:0]    tx;
        logic [`JTD_SR_W-1:0]    rx;
        logic                    rvalid;
        logic                    rst_oe;
    } jtd_probe_t;

endpackage

// ### core/jtd_probe.sv
`timescale 1ns/1ps
`default_nettype none
`include "jtd_cfg.svh"

module jtd_probe (
    input  wire logic                    sys_clk,
    input  wire logic                    sys_rst,
    input  wire logic                    req_valid,
    output logic                         req_ready,
    input  wire logic [1:0]              req_kind,
    input  wire logic [`JTD_LEN_W-1:0]   req_nbits,
    input  wire logic [`JTD_SR_W-1:0]    req_data,
    output logic                         resp_valid,
    output logic      [`JTD_SR_W-1:0]    resp_data,
    input  wire logic                    sys_reset_req,
    output logic                         sys_reset_seen,
    jtd_if.probe                         jif
);
    import jtd_pkg::*;

    jtd_probe_t            q, d;
    logic [1:0]            in_s;
    logic                  tick, rise, fall;

    // Line levels come from the other party's pins
    // Reset line inverted so the synchroniser's reset level reads as idle
    jtd_sync #(.W(2)) u_sync (
        .clk (sys_clk),
        .rst (sys_rst),
        .d   ({jif.tdo_line, ~jif.rst_line}),
        .q   (in_s)
    );

    // ------------------------------------------------------------------
    // Clock divider and shift sequencer
    // ------------------------------------------------------------------
    assign tick      = (q.div == `JTD_TCK_HALF - 3'h1);
    assign rise      = tick && !q.tck;
    assign fall      = tick && q.tck;
    // One idle tck with tms low first, so a TAP just reset reaches idle
    assign req_ready = (q.st == P_IDL) && fall && !q.tms;

    always_comb begin
        d        = q;
        d.rvalid = 1'b0;
        d.rst_oe = sys_reset_req;
        d.div    = tick ? 3'h0 : q.div + 3'h1;
        if (tick) begin
            d.tck = ~q.tck;
        end
        if (rise && q.samp) begin
            d.rx[q.idx] = in_s[1];
        end
        // Outputs change on the falling edge, device samples on the rising
        if (fall) begin
            d.samp = 1'b0;
            unique case (q.st)
                P_RST: begin
                    d.tms = 1'b1;
                    d.cnt = q.cnt + `JTD_LEN_W'(1);
                    if (q.cnt == `JTD_RESET_TMS_N - `JTD_LEN_W'(1)) begin
                        d.st  = P_IDL;
                        d.cnt = '0;
                    end
                end
                P_IDL: begin
                    d.tms = 1'b0;
                    if (req_valid && !q.tms) begin
                        if (req_kind == `JTD_KIND_RESET) begin
                            d.st  = P_RST;
                            d.tms = 1'b1;
                            d.cnt = `JTD_LEN_W'(1);
                        end else begin
                            d.st  = P_SEL;
                            d.tms = 1'b1;
                            d.tx  = req_data;
                            d.rx  = '0;
                            d.n   = (req_nbits == '0) ? `JTD_LEN_W'(1) : req_nbits;
                            d.seq = (req_kind == `JTD_KIND_IR) ? 4'h1 : 4'h0;
                            d.cnt = (req_kind == `JTD_KIND_IR) ? `JTD_LEN_W'(3)
                                                               : `JTD_LEN_W'(2);
                        end
                    end
                end
                P_SEL: begin
                    d.tms = q.seq[0];
                    d.seq = {1'b0, q.seq[3:1]};
                    d.cnt = q.cnt - `JTD_LEN_W'(1);
                    if (q.cnt == `JTD_LEN_W'(1)) begin
                        d.st  = P_SHF;
                        d.cnt = '0;
                    end
                end
                P_SHF: begin
                    d.tdi  = q.tx[q.cnt];
                    d.tms  = (q.cnt == q.n - `JTD_LEN_W'(1));
                    d.samp = 1'b1;
                    d.idx  = q.cnt;
                    d.cnt  = q.cnt + `JTD_LEN_W'(1);
                    if (q.cnt == q.n - `JTD_LEN_W'(1)) begin
                        d.st  = P_EXT;
                        d.cnt = '0;
                    end
                end
                P_EXT: begin
                    d.tms = (q.cnt == '0);
                    d.cnt = q.cnt + `JTD_LEN_W'(1);
                    if (q.cnt != '0) begin
                        d.st     = P_IDL;
                        d.cnt    = '0;
                        d.rvalid = 1'b1;
                    end
                end
                default: d.st = P_RST;
            endcase
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            q    <= '0;
            q.st <= P_RST;
        end else begin
            q <= d;
        end
    end

    assign jif.tck        = q.tck;
    assign jif.tms        = q.tms;
    assign jif.tdi        = q.tdi;
    assign jif.rst_o      = 1'b0;
    assign jif.rst_oe     = q.rst_oe;
    assign sys_reset_seen = in_s[0];
    assign resp_valid     = q.rvalid;
    assign resp_data      = q.rx;
endmodule

`default_nettype wire

// ### core/jtd_sync.sv
`timescale 1ns/1ps
`default_nettype none

module jtd_sync #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s1_q <= '0;
            s2_q <= '0;
        end else begin
            s1_q <= d;
            s2_q <= s1_q;
        end
    end

    assign q = s2_q;
endmodule

`default_nettype wire

// ### core/jtd_tap.sv
`timescale 1ns/1ps
`default_nettype none
`include "jtd_cfg.svh"

module jtd_tap (
    input  wire logic                     sys_clk,
    input  wire logic                     sys_rst,
    input  wire logic                     scan_port_enable_fuse,
    input  wire logic                     scan_port_soft_disable,
    input  wire logic                     ocd_enable,
    output logic                          pins_gpio_mode,
    output logic                          pullup_en,
    input  wire logic [`JTD_BSR_W-1:0]    bsr_in,
    output logic      [`JTD_BSR_W-1:0]    bsr_out,
    output logic                          bsr_drive,
    output logic                          prog_mode,
    output logic      [`JTD_PCMD_W-1:0]   prog_cmd,
    output logic                          prog_cmd_stb,
    input  wire logic [`JTD_PCMD_W-1:0]   prog_rdata,
    input  wire logic [`JTD_ISC_W-1:0]    iscan_in,
    output logic      [`JTD_ISC_W-1:0]    iscan_out,
    input  wire logic [`JTD_ADDR_W-1:0]   pc,
    input  wire logic                     pc_valid,
    input  wire logic                     flow_change,
    input  wire logic                     brk_instr,
    input  wire logic [`JTD_ADDR_W-1:0]   daddr,
    input  wire logic                     dacc_valid,
    output logic                          halt,
    jtd_if.dev                            jif
);
    import jtd_pkg::*;

    localparam int XW = 2 + `JTD_BSR_W + `JTD_PCMD_W + `JTD_ISC_W;

    jtd_dtck_t                t_q, t_d;
    jtd_dsys_t                s_q, s_d;
    logic [XW-1:0]            x_s;
    logic                     en_s, ocd_s;
    logic [`JTD_BSR_W-1:0]    bsr_s;
    logic [`JTD_PCMD_W-1:0]   prd_s;
    logic [`JTD_ISC_W-1:0]    isc_s;
    logic                     tgl_s;
    logic [`JTD_IR_W-1:0]     eff;
    logic [`JTD_LEN_W-1:0]    len;
    logic                     port_en;

    // ------------------------------------------------------------------
    // Port enable and crossings
    // ------------------------------------------------------------------
    assign port_en        = scan_port_enable_fuse & ~scan_port_soft_disable;
    assign pins_gpio_mode = ~port_en;
    assign pullup_en      = port_en;

    // Pin and system-side levels reach TCK logic through two flops
    jtd_sync #(.W(XW)) u_tck_sync (
        .clk (jif.tck),
        .rst (sys_rst),
        .d   ({port_en, ocd_enable, bsr_in, prog_rdata, iscan_in}),
        .q   (x_s)
    );
    assign {en_s, ocd_s, bsr_s, prd_s, isc_s} = x_s;

    // Update toggle; words are stable long before it arrives
    jtd_sync #(.W(1)) u_sys_sync (
        .clk (sys_clk),
        .rst (sys_rst),
        .d   (t_q.tgl),
        .q   (tgl_s)
    );

    // ------------------------------------------------------------------
    // TAP controller
    // ------------------------------------------------------------------
    function automatic jtd_tap_t tap_next(input jtd_tap_t st, input logic tms);
        unique case (st)
            T_TLR:   tap_next = tms ? T_TLR : T_RTI;
            T_RTI:   tap_next = tms ? T_SDS : T_RTI;
            T_SDS:   tap_next = tms ? T_SIS : T_CDR;
            T_CDR:   tap_next = tms ? T_E1D : T_SDR;
            T_SDR:   tap_next = tms ? T_E1D : T_SDR;
            T_E1D:   tap_next = tms ? T_UDR : T_PDR;
            T_PDR:   tap_next = tms ? T_E2D : T_PDR;
            T_E2D:   tap_next = tms ? T_UDR : T_SDR;
            T_UDR:   tap_next = tms ? T_SDS : T_RTI;
            T_SIS:   tap_next = tms ? T_TLR : T_CIR;
            T_CIR:   tap_next = tms ? T_E1I : T_SIR;
            T_SIR:   tap_next = tms ? T_E1I : T_SIR;
            T_E1I:   tap_next = tms ? T_UIR : T_PIR;
            T_PIR:   tap_next = tms ? T_E2I : T_PIR;
            T_E2I:   tap_next = tms ? T_UIR : T_SIR;
            T_UIR:   tap_next = tms ? T_SDS : T_RTI;
            default: tap_next = T_TLR;
        endcase
    endfunction

    // Debug chains and commands fall back to bypass when not allowed
    always_comb begin
        eff = t_q.ir;
        if ((t_q.ir == `JTD_I_INTSCAN || t_q.ir == `JTD_I_BRKSCAN) && !ocd_s) begin
            eff = `JTD_I_BYPASS;
        end
        if (t_q.ir == `JTD_I_PROG_CMD && !t_q.pmode) begin
            eff = `JTD_I_BYPASS;
        end
    end

    always_comb begin
        unique case (t_q.st)
            T_SIR: len = `JTD_LEN_W'(`JTD_IR_W);
            default: begin
                case (eff)
                    `JTD_I_IDCODE:  len = `JTD_ID_W;
                    `JTD_I_EXTEST,
                    `JTD_I_SAMPLE:  len = `JTD_LEN_W'(`JTD_BSR_W);
                    `JTD_I_PROG_EN: len = `JTD_LEN_W'(`JTD_PKEY_W);
                    `JTD_I_PROG_CMD: len = `JTD_LEN_W'(`JTD_PCMD_W);
                    `JTD_I_INTSCAN: len = `JTD_LEN_W'(`JTD_ISC_W);
                    `JTD_I_BRKSCAN: len = `JTD_LEN_W'(`JTD_BRK_W);
                    default:        len = `JTD_LEN_W'(1);
                endcase
            end
        endcase
    end

    always_comb begin
        t_d    = t_q;
        t_d.st = tap_next(t_q.st, jif.tms);
        unique case (t_q.st)
            T_TLR: t_d.ir = `JTD_I_IDCODE;
            T_CIR: t_d.sr = `JTD_SR_W'(`JTD_IR_CAPTURE);
            T_SIR, T_SDR: begin
                // Single shift path, LSB leaves first
                for (int i = 0; i < `JTD_SR_W; i++) begin
                    if (i == int'(len) - 1) begin
                        t_d.sr[i] = jif.tdi;
                    end else if (i < `JTD_SR_W - 1) begin
                        t_d.sr[i] = t_q.sr[i+1];
                    end else begin
                        t_d.sr[i] = 1'b0;
                    end
                end
            end
            T_UIR: t_d.ir = t_q.sr[`JTD_IR_W-1:0];
            T_CDR: begin
                case (eff)
                    `JTD_I_IDCODE:   t_d.sr = `JTD_SR_W'(`JTD_IDCODE);
                    `JTD_I_EXTEST,
                    `JTD_I_SAMPLE:   t_d.sr = `JTD_SR_W'(bsr_s);
                    `JTD_I_PROG_CMD: t_d.sr = `JTD_SR_W'(prd_s);
                    `JTD_I_INTSCAN:  t_d.sr = `JTD_SR_W'(isc_s);
                    `JTD_I_BRKSCAN:  t_d.sr = t_q.brk;
                    default:         t_d.sr = '0;
                endcase
            end
            T_UDR: begin
                case (eff)
                    `JTD_I_EXTEST:   t_d.bsr = t_q.sr[`JTD_BSR_W-1:0];
                    `JTD_I_PROG_EN:  t_d.pmode = (t_q.sr[`JTD_PKEY_W-1:0] == `JTD_PROG_KEY);
                    `JTD_I_PROG_CMD: t_d.pcmd = t_q.sr[`JTD_PCMD_W-1:0];
                    `JTD_I_INTSCAN:  t_d.isc = t_q.sr[`JTD_ISC_W-1:0];
                    `JTD_I_BRKSCAN:  t_d.brk = t_q.sr;
                    default:         t_d.bsr = t_q.bsr;
                endcase
                t_d.tgl = ~t_q.tgl;
            end
            default: t_d.st = t_d.st;
        endcase
        if (!en_s) begin
            t_d.st    = T_TLR;
            t_d.ir    = `JTD_I_IDCODE;
            t_d.pmode = 1'b0;
        end
    end

    // Only power-on reset; no dedicated TAP reset pin exists
    always_ff @(posedge jif.tck or posedge sys_rst) begin
        if (sys_rst) begin
            t_q    <= '0;
            t_q.st <= T_TLR;
            t_q.ir <= `JTD_I_IDCODE;
        end else begin
            t_q <= t_d;
        end
    end

    assign jif.tdo    = t_q.sr[0];
    assign jif.tdo_oe = (t_q.st == T_SIR) || (t_q.st == T_SDR);

    // ------------------------------------------------------------------
    // System side: updates and break logic
    // ------------------------------------------------------------------
    logic pc_hit, da_hit;

    always_comb begin
        pc_hit = pc_valid && s_q.brk[`JTD_BRK_PC_EN]
            && pc >= s_q.brk[`JTD_BRK_PC_LO +: `JTD_ADDR_W]
            && pc <= s_q.brk[`JTD_BRK_PC_HI +: `JTD_ADDR_W];
        da_hit = dacc_valid && s_q.brk[`JTD_BRK_DA_EN]
            && daddr >= s_q.brk[`JTD_BRK_DA_LO +: `JTD_ADDR_W]
            && daddr <= s_q.brk[`JTD_BRK_DA_HI +: `JTD_ADDR_W];
    end

    always_comb begin
        s_d          = s_q;
        s_d.tgl_last = tgl_s;
        s_d.pstb     = 1'b0;
        if (tgl_s != s_q.tgl_last) begin
            s_d.bsr       = t_q.bsr;
            s_d.bsr_drive = (t_q.ir == `JTD_I_EXTEST);
            s_d.pstb      = t_q.pmode && (t_q.ir == `JTD_I_PROG_CMD);
            s_d.pcmd      = t_q.pcmd;
            s_d.pmode     = t_q.pmode;
            s_d.isc       = t_q.isc;
            s_d.brk       = t_q.brk;
        end
        if (!port_en) begin
            s_d.pmode     = 1'b0;
            s_d.bsr_drive = 1'b0;
        end
        // Same address in low and high bound is a single-address match
        s_d.halt = ocd_enable && (brk_instr || pc_hit || da_hit
            || (flow_change && s_q.brk[`JTD_BRK_FLOW])
            || (pc_valid && s_q.brk[`JTD_BRK_STEP]));
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign bsr_out      = s_q.bsr;
    assign bsr_drive    = s_q.bsr_drive;
    assign prog_mode    = s_q.pmode;
    assign prog_cmd     = s_q.pcmd;
    assign prog_cmd_stb = s_q.pstb;
    assign iscan_out    = s_q.isc;
    assign halt         = s_q.halt;
endmodule

`default_nettype wire
